// >>> design/polp_pkg.sv
// Package for the parallel output line port: command carriers, modes, timing counts.
// Assumes a single 250 MHz system clock shared by every user of the package.
package polp_pkg;

	// Combine modes carried with each port write
	typedef enum logic [1:0] {
		POLP_MODE_LOAD = 2'h0,
		POLP_MODE_OR   = 2'h1,
		POLP_MODE_AND  = 2'h2,
		POLP_MODE_XOR  = 2'h3
	} polp_mode_t;

	localparam int           POLP_LINES        = 32;
	localparam int           POLP_BYTES        = 4;
	localparam int           POLP_SPARES       = 5;
	localparam int           POLP_ADDR_W       = 12;
	localparam int           POLP_JUMPER_W     = 10;
	localparam int           POLP_JUMPER_LSB   = 2;
	localparam logic [1:0]   POLP_ADDR_LOW     = 2'h0;
	localparam logic [31:0]  POLP_WORD_RESET   = 32'h0000_0000;
	localparam logic [4:0]   POLP_SPARE_RESET  = 5'h00;
	localparam logic [11:0]  POLP_ADDR_DIGITAL = 12'hc90;
	localparam logic [11:0]  POLP_ADDR_ANALOG  = 12'h990;

	// Timing: figures in ps, cycle counts derived from the 4 ns clock
	localparam int POLP_CLK_PERIOD_PS  = 4000;
	localparam int POLP_BUS_CYCLE_PS   = 2150000;
	localparam int POLP_STARTUP_PS     = 200000;
	localparam int POLP_JITTER_PS      = 100000;
	localparam int POLP_WRITE_CYCLES   = 5;
	localparam int POLP_LEADIN_PS      = 10950000;
	localparam int POLP_BUS_CYCLE_CLKS = (POLP_BUS_CYCLE_PS + POLP_CLK_PERIOD_PS - 1) / POLP_CLK_PERIOD_PS;
	localparam int POLP_STARTUP_CLKS   = (POLP_STARTUP_PS + POLP_CLK_PERIOD_PS - 1) / POLP_CLK_PERIOD_PS;

	// One command on the sequencer peripheral bus
	typedef struct packed {
		logic [11:0] addr;
		logic [2:0]  mode;
		logic [31:0] pattern;
	} polp_write_t;

	// Spare line command: on or off for one selected line
	typedef struct packed {
		logic       spare_line_on;
		logic       spare_line_off;
		logic [2:0] sel;
	} polp_spare_t;

endpackage : polp_pkg

// >>> design/polp_port.sv
// Parallel output line port: 32 lines plus five spare lines, driven from the sequencer peripheral bus.
// Assumes commands come from logic on sys_clk; jumper straps come from pins and are synchronised.
// Operation
// - Thirty-two output lines, each tied to one bit of the stored word.
// - New word is load, OR, AND or XOR of pattern with old word.
// - New word reaches the lines one byte at a time, low byte first.
// - Consecutive byte updates are one bus cycle apart, jitter under 100 ns.
// - A bus cycle is 2.150 us; a whole write takes five bus cycles.
// - Write lead-in is 10.950 us: 200 ns startup plus five bus cycles.
// - Only accesses to the jumper-configured board address are answered; spare commands carry no address and are answered without any address check.
// - Board address bits 2 to 11 come from ten jumpers; bits 0, 1 zero.
// - A fitted jumper reads as one, an absent jumper as zero.
// - Zero word drives all lines low; all-ones word drives all lines high.
// - Five separately controlled spare output lines besides the 32-line port.
// - Spare-on drives selected line high; spare-off returns it low.
`timescale 1ns/1ps
`default_nettype none

module polp_port #(
	parameter int BUS_CYCLE_CLKS = polp_pkg::POLP_BUS_CYCLE_CLKS, // Clocks per bus cycle
	parameter int STARTUP_CLKS   = polp_pkg::POLP_STARTUP_CLKS    // Clocks of startup delay
) (
	input  wire logic                 sys_clk,        // System clock, 250 MHz
	input  wire logic                 rstn,           // Async reset, active low
	input  wire logic                 wr_valid,       // Write command present
	input  wire polp_pkg::polp_write_t wr_cmd,        // Address, mode, pattern
	output logic                      wr_ready,       // Port can take a write
	input  wire logic                 spare_valid,    // Spare command present
	input  wire polp_pkg::polp_spare_t spare_cmd,     // Spare on/off and line
	input  wire logic [9:0]           jumper_n,       // Address jumper pins, low when fitted
	output logic [31:0]               out_lines,      // Parallel output lines
	output logic [4:0]                spare_lines,    // Spare output lines
	output logic                      mode_err,       // Pulse: illegal mode on matching write
	output logic                      busy            // Write in progress
);

	typedef enum logic [1:0] {
		POLP_IDLE  = 2'h0,
		POLP_START = 2'h1,
		POLP_BYTE  = 2'h2,
		POLP_TAIL  = 2'h3
	} polp_state_t;

	// One down-counter serves the startup and every bus cycle.
	// Sized for the sum of the two clock counts plus one,
	// so a larger bus-cycle parameter never wraps the count.
	localparam int CNT_W = $clog2(BUS_CYCLE_CLKS + STARTUP_CLKS + 1);

	// Sequencer state, shared down-counter and byte index.
	// The byte index runs 0 to 3 while bytes are applied.
	polp_state_t       state_ff;
	logic [CNT_W-1:0]  cnt_ff;
	logic [2:0]        step_ff;

	// Target word and the word on the pins.
	// They differ only while a write is being staged.
	logic [31:0]       word_ff;
	logic [31:0]       out_ff;
	logic [4:0]        spare_ff;
	logic              err_ff;

	// Jumper synchroniser stages
	logic [9:0]        jmp_meta_ff;
	logic [9:0]        jmp_sync_ff;

	// Decode of the current bus command
	logic [11:0]       board_addr;
	logic              hit;
	logic              mode_ok;
	logic [31:0]       nxt_word;

	// Merge pattern with the stored word
	function automatic logic [31:0] combine(input logic [2:0] mode, input logic [31:0] old,
		input logic [31:0] pat);
		unique case (mode[1:0])
			polp_pkg::POLP_MODE_LOAD: combine = pat;
			polp_pkg::POLP_MODE_OR:   combine = old | pat;
			polp_pkg::POLP_MODE_AND:  combine = old & pat;
			polp_pkg::POLP_MODE_XOR:  combine = old ^ pat;
		endcase
	endfunction : combine

	// Jumper straps are pins, so two flops before the address compare
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			jmp_meta_ff <= 10'h000;
			jmp_sync_ff <= 10'h000;
		end else begin
			jmp_meta_ff <= ~jumper_n;
			jmp_sync_ff <= jmp_meta_ff;
		end
	end

	// Board address from jumpers; low two bits fixed at zero
	assign board_addr = {jmp_sync_ff, polp_pkg::POLP_ADDR_LOW};
	assign hit        = wr_valid && (wr_cmd.addr == board_addr);
	assign mode_ok    = (wr_cmd.mode[2] == 1'b0);
	assign nxt_word   = combine(wr_cmd.mode, word_ff, wr_cmd.pattern);
	// Ready and busy are combinational so a new write can be taken
	// in the very cycle the previous one closes; there is no queue,
	// so a write offered while busy is simply not taken.
	assign wr_ready   = (state_ff == POLP_IDLE);
	assign busy       = (state_ff != POLP_IDLE);

	// Sequencer: startup, four byte steps one bus cycle apart, then the fifth cycle
	// Each count reloads in the cycle of the previous expiry, so byte spacing does not drift
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			state_ff <= POLP_IDLE;
			cnt_ff   <= '0;
			step_ff  <= 3'h0;
		end else begin
			unique case (state_ff)
				// Wait for an addressed write with a legal mode.
				// Illegal modes never leave idle, so the lines cannot move.
				POLP_IDLE: begin
					if (hit && mode_ok) begin
						state_ff <= POLP_START;
						cnt_ff   <= CNT_W'(STARTUP_CLKS - 1);
						step_ff  <= 3'h0;
					end
				end
				// Startup delay before the first bus cycle begins
				POLP_START: begin
					if (cnt_ff == '0) begin
						state_ff <= POLP_BYTE;
						cnt_ff   <= CNT_W'(BUS_CYCLE_CLKS - 1);
					end else begin
						cnt_ff <= cnt_ff - 1'b1;
					end
				end
				// Each expiry applies one byte and reloads the full bus cycle.
				// Reload on expiry keeps the spacing exact, with no jitter.
				POLP_BYTE: begin
					if (cnt_ff == '0) begin
						cnt_ff  <= CNT_W'(BUS_CYCLE_CLKS - 1);
						step_ff <= step_ff + 3'h1;
						if (step_ff == 3'(polp_pkg::POLP_BYTES - 1))
							state_ff <= POLP_TAIL;
					end else begin
						cnt_ff <= cnt_ff - 1'b1;
					end
				end
				POLP_TAIL: begin
					// Fifth bus cycle closes the write
					if (cnt_ff == '0)
						state_ff <= POLP_IDLE;
					else
						cnt_ff <= cnt_ff - 1'b1;
				end
			endcase
		end
	end

	// Target word is captured when the write is taken.
	// Combining against the target, not the pins, means a write that
	// follows a finished one always sees the whole previous word.
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn)
			word_ff <= polp_pkg::POLP_WORD_RESET;
		else if (state_ff == POLP_IDLE && hit && mode_ok)
			word_ff <= nxt_word;
	end

	// Output bytes follow the target one at a time, low byte first.
	// Downstream equipment sees intermediate words mid-write;
	// a user needing atomic changes must confine them to one byte.
	generate
		for (genvar b = 0; b < polp_pkg::POLP_BYTES; b++) begin : g_byte
			always_ff @(posedge sys_clk or negedge rstn) begin
				if (!rstn)
					out_ff[8*b +: 8] <= 8'h00;
				else if (state_ff == POLP_BYTE && cnt_ff == '0 && step_ff == 3'(b))
					out_ff[8*b +: 8] <= word_ff[8*b +: 8];
			end
		end
	endgenerate

	// Illegal mode on an addressed write is flagged and the word is untouched.
	// The flag is a single-cycle pulse; a caller must watch for it
	// on the cycle after the command is offered.
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn)
			err_ff <= 1'b0;
		else
			err_ff <= (state_ff == POLP_IDLE) && hit && !mode_ok;
	end

	// Spare lines; on takes priority if both bits are set.
	// Selects above the last spare are dropped rather than wrapped,
	// so a bad select can never disturb a real line.
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			spare_ff <= polp_pkg::POLP_SPARE_RESET;
		end else if (spare_valid && spare_cmd.sel < 3'(polp_pkg::POLP_SPARES)) begin
			if (spare_cmd.spare_line_on)
				spare_ff[spare_cmd.sel] <= 1'b1;
			else if (spare_cmd.spare_line_off)
				spare_ff[spare_cmd.sel] <= 1'b0;
		end
	end

	// Pins come straight from flops, so they never glitch.
	// Bit n of the stored word drives line n.
	assign out_lines   = out_ff;
	assign spare_lines = spare_ff;
	assign mode_err    = err_ff;

endmodule : polp_port

`default_nettype wire

// >>> dv/polp_port_chk.sv
// Checker for the parallel output line port, bound to polp_port.
// Assumes jumpers stay steady while writes are in flight.
`timescale 1ns/1ps
`default_nettype none
module polp_port_chk (
	input wire logic                  sys_clk,     // Clock
	input wire logic                  rstn,        // Reset, active low
	input wire logic                  wr_valid,    // Write present
	input wire polp_pkg::polp_write_t wr_cmd,      // Write command
	input wire logic                  wr_ready,    // Port idle
	input wire logic                  spare_valid, // Spare present
	input wire polp_pkg::polp_spare_t spare_cmd,   // Spare command
	input wire logic [9:0]            jumper_n,    // Jumper pins
	input wire logic [31:0]           out_lines,   // Output lines
	input wire logic [4:0]            spare_lines, // Spare lines
	input wire logic                  mode_err,    // Mode error pulse
	input wire logic                  busy         // Write running
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	logic [31:0] prev_ff;
	logic        hit;
	logic        sp_ok;
	logic [3:0]  chg;
	// Last sample of the lines, to see which bytes moved
	always_ff @(posedge sys_clk or negedge rstn) if (!rstn) prev_ff <= '0; else prev_ff <= out_lines;
	assign hit = wr_valid && wr_ready && wr_cmd.addr == {~jumper_n, 2'h0};
	assign sp_ok = spare_valid && spare_cmd.sel < 3'h5;
	for (genvar i = 0; i < 4; i++) assign chg[i] = out_lines[8*i+:8] != prev_ff[8*i+:8];
	// A write holds the port for the startup and five bus cycles, then frees it
	sequence run_s; busy [*8] ##[1:40] !busy; endsequence
	take_a: assert property (hit && !wr_cmd.mode[2] |=> busy) else $error("write not taken");
	mode_err_a: assert property (hit && wr_cmd.mode[2] |=> mode_err && !busy) else $error("bad mode run");
	no_err_a: assert property (!(hit && wr_cmd.mode[2]) |=> !mode_err) else $error("stray mode error");
	ready_busy_a: assert property (wr_ready != busy) else $error("ready and busy agree");
	idle_hold_a: assert property (chg != 4'h0 |-> busy || $past(busy)) else $error("lines moved idle");
	one_byte_a: assert property ($onehot0(chg)) else $error("two bytes moved together");
	run_len_a: assert property ($rose(busy) |-> run_s) else $error("write length wrong");
	spare_on_a: assert property (sp_ok && spare_cmd.spare_line_on |=> spare_lines[$past(spare_cmd.sel)])
		else $error("spare not raised");
	spare_off_a: assert property (sp_ok && spare_cmd.spare_line_off && !spare_cmd.spare_line_on
		|=> !spare_lines[$past(spare_cmd.sel)]) else $error("spare not lowered");
	spare_hold_a: assert property (!sp_ok |=> $stable(spare_lines)) else $error("spare moved");
endmodule : polp_port_chk
bind polp_port polp_port_chk polp_port_chk_inst (.sys_clk, .rstn, .wr_valid, .wr_cmd, .wr_ready, .spare_valid,
	.spare_cmd, .jumper_n, .out_lines, .spare_lines, .mode_err, .busy);
`default_nettype wire

// >>> dv/polp_bus_model.sv
// Sequencer bus model: issues port writes and spare commands on request.
// Assumes calls are made off the rising edge of sys_clk.
`timescale 1ns/1ps
`default_nettype none
module polp_bus_model (
	input  wire logic                 sys_clk,     // Clock
	input  wire logic                 wr_ready,    // Port idle
	output var logic                  wr_valid,    // Write present
	output var polp_pkg::polp_write_t wr_cmd,      // Write command
	output var logic                  spare_valid, // Spare present
	output var polp_pkg::polp_spare_t spare_cmd    // Spare command
);
	initial begin
		wr_valid = 1'b0;
		spare_valid = 1'b0;
		wr_cmd = '0;
		spare_cmd = '0;
	end
	// Waits out the running write, then scrambles the released fields so stale values never pass
	task automatic write(input logic [11:0] a, input logic [2:0] m, input logic [31:0] p);
		// Look at ready only once the previous take edge has settled
		@(negedge sys_clk);
		while (wr_ready !== 1'b1) @(negedge sys_clk);
		@(posedge sys_clk);
		wr_valid <= 1'b1;
		wr_cmd <= '{a, m, p};
		@(posedge sys_clk);
		wr_valid <= 1'b0;
		wr_cmd <= ~wr_cmd;
	endtask : write
	// One spare command lasts exactly one cycle
	task automatic spare(input logic on, input logic off, input logic [2:0] sel);
		@(posedge sys_clk);
		spare_valid <= 1'b1;
		spare_cmd <= '{on, off, sel};
		@(posedge sys_clk);
		spare_valid <= 1'b0;
	endtask : spare
endmodule : polp_bus_model
`default_nettype wire

// >>> dv/polp_port_tb.sv
// Bench for the parallel output line port, with the bus model as controller.
// Assumes shortened bus-cycle and startup counts; expectations follow them.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
	$display("ERROR %s exp %h got %h", nm, e, g); end end
module polp_port_tb;
	localparam int BC = 4;
	logic                  sys_clk = 1'b0;
	logic                  rstn = 1'b0;
	logic                  wr_valid, wr_ready, spare_valid, mode_err, busy;
	polp_pkg::polp_write_t wr_cmd;
	polp_pkg::polp_spare_t spare_cmd;
	logic [9:0]            jumper_n = 10'h0db; // Fitted pattern for c90
	logic [31:0]           out_lines;
	logic [4:0]            spare_lines;
	int                    n_mismatch = 0, comparisons = 0, cyc = 0;
	always #2 sys_clk = ~sys_clk;
	polp_port #(.BUS_CYCLE_CLKS(BC), .STARTUP_CLKS(2)) polp_port_inst (.sys_clk, .rstn, .wr_valid, .wr_cmd,
		.wr_ready, .spare_valid, .spare_cmd, .jumper_n, .out_lines, .spare_lines, .mode_err, .busy);
	polp_bus_model polp_bus_model_inst (.sys_clk, .wr_ready, .wr_valid, .wr_cmd, .spare_valid, .spare_cmd);
	// Write and follow the lines; patterns are picked so every byte moves
	task automatic wr_chk(input logic [11:0] a, input logic [2:0] m, input logic [31:0] p, e);
		logic [31:0] v;
		int          k, t;
		v = out_lines;
		k = 0;
		t = 0;
		polp_bus_model_inst.write(a, m, p);
		repeat (40) begin
			@(negedge sys_clk);
			if (out_lines !== v && k < 4) begin
				v[8*k+:8] = e[8*k+:8];
				`CHK("staged word", v, out_lines)
				if (k > 0) `CHK("byte spacing", BC, t)
				k++;
				t = 0;
			end
			t++;
		end
		`CHK("bytes moved", 4, k)
		`CHK("final word", e, out_lines)
		`CHK("busy done", 1'b0, busy)
	endtask : wr_chk
	task automatic t_modes;
		wr_chk(polp_pkg::POLP_ADDR_DIGITAL, 3'h0, 32'h1234_5678, 32'h1234_5678);
		wr_chk(polp_pkg::POLP_ADDR_DIGITAL, 3'h1, 32'h8080_8080, 32'h92b4_d6f8);
		wr_chk(polp_pkg::POLP_ADDR_DIGITAL, 3'h2, 32'h0f0f_0f0f, 32'h0204_0608);
		wr_chk(polp_pkg::POLP_ADDR_DIGITAL, 3'h3, 32'hffff_ffff, 32'hfdfb_f9f7);
		wr_chk(polp_pkg::POLP_ADDR_DIGITAL, 3'h0, 32'hffff_ffff, 32'hffff_ffff);
		wr_chk(polp_pkg::POLP_ADDR_DIGITAL, 3'h0, 32'h0, 32'h0);
	endtask : t_modes
	// Bad mode and foreign address must leave the lines alone
	task automatic t_refuse;
		polp_bus_model_inst.write(polp_pkg::POLP_ADDR_DIGITAL, 3'h5, 32'ha5a5_a5a5);
		@(negedge sys_clk);
		`CHK("mode error", 1'b1, mode_err)
		polp_bus_model_inst.write(polp_pkg::POLP_ADDR_ANALOG, 3'h0, 32'ha5a5_a5a5);
		repeat (40) @(negedge sys_clk);
		`CHK("refused lines", 32'h0, out_lines)
	endtask : t_refuse
	// Restrap for the analogue address; synchroniser needs a few cycles
	task automatic t_jumper;
		@(posedge sys_clk);
		jumper_n <= 10'h19b;
		repeat (4) @(negedge sys_clk);
		wr_chk(polp_pkg::POLP_ADDR_ANALOG, 3'h0, 32'h5a5a_c3c3, 32'h5a5a_c3c3);
	endtask : t_jumper
	task automatic t_spare;
		for (int i = 0; i < 5; i++) polp_bus_model_inst.spare(1'b1, 1'b0, 3'(i));
		polp_bus_model_inst.spare(1'b0, 1'b1, 3'h5);
		@(negedge sys_clk);
		`CHK("spares on", 5'h1f, spare_lines)
		for (int i = 0; i < 5; i += 2) polp_bus_model_inst.spare(1'b0, 1'b1, 3'(i));
		@(negedge sys_clk);
		`CHK("spares off", 5'h0a, spare_lines)
	endtask : t_spare
	task automatic final_report;
		$display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : final_report
	// Hang guard well above the expected run of some 380 cycles
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 3000) begin
			n_mismatch++;
			final_report();
		end
	end
	initial begin
		repeat (12) @(posedge sys_clk);
		rstn <= 1'b1;
		repeat (3) @(negedge sys_clk);
		`CHK("reset lines", 32'h0, out_lines)
		`CHK("reset spares", 5'h0, spare_lines)
		t_modes();
		t_refuse();
		t_spare();
		t_jumper();
		final_report();
	end
endmodule : polp_port_tb
`default_nettype wire
